// ===== rtl/pot_status_terminal_defs.svh
`ifndef POT_STATUS_TERMINAL_DEFS_SVH
`define POT_STATUS_TERMINAL_DEFS_SVH

// ---------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------
`define ADDR_VOL_WIPER0   4'h0
`define ADDR_VOL_WIPER1   4'h1
`define ADDR_NV_WIPER0    4'h2
`define ADDR_NV_WIPER1    4'h3
`define ADDR_TERM_LOW     4'h4
`define ADDR_LOCK_STATE   4'h5
`define ADDR_VOL_WIPER2   4'h6
`define ADDR_VOL_WIPER3   4'h7
`define ADDR_NV_WIPER2    4'h8
`define ADDR_NV_WIPER3    4'h9
`define ADDR_TERM_HIGH    4'ha
`define ADDR_GP_FIRST     4'hb
`define ADDR_GP_LAST      4'hf

// ---------------------------------------------------------------
// status field positions
// ---------------------------------------------------------------
`define ST_RSV_TOP_HI     8
`define ST_RSV_TOP_LO     7
`define ST_LOCK_NET3      6
`define ST_LOCK_NET2      5
`define ST_NV_BUSY        4
`define ST_LOCK_NET1      3
`define ST_LOCK_NET0      2
`define ST_RSV_ONE        1
`define ST_PROTECT        0

// ---------------------------------------------------------------
// terminal control field positions and reset values
// ---------------------------------------------------------------
`define TC_RESERVED_TOP   8
`define TC_UPPER_HI       7
`define TC_UPPER_LO       4
`define TC_LOWER_HI       3
`define TC_LOWER_LO       0
`define TC_RESET          9'h1ff
`define NET_CTRL_RESET    4'hf
`define NET_SHDN_BIT      3
`define NET_A_BIT         2
`define NET_W_BIT         1
`define NET_B_BIT         0

`endif

// ===== rtl/pot_status_terminal_pkg.sv
package pot_status_terminal_pkg;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_RUN  = 2'b01
  } phase_t;

  typedef struct packed {
    logic [3:0] staged;
    logic [3:0] applied;
    logic       pending;
  } net_ctrl_state_t;

  typedef struct packed {
    phase_t     phase;
    logic [3:0] lock;
    logic       nv_protect;
    logic [8:0] rd_data;
    logic       rd_valid;
    logic       cmd_error;
    logic [3:0] vol_we;
    logic [3:0] nv_we;
    logic       gp_we;
    logic [8:0] wr_data;
    logic       scl_q;
    logic       sda_q;
    logic       apply;
    logic [3:0] shutdown;
    logic [3:0] term_a;
    logic [3:0] term_w;
    logic [3:0] term_b;
  } top_state_t;

endpackage

// ===== rtl/pin_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // pins and synchronised copy
  input  wire logic [WIDTH-1:0] pin,
  input  wire logic [WIDTH-1:0] reset_value,
  output logic      [WIDTH-1:0] level
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  // ---------------------------------------------------------------
  // two stages, second one is the only reader of the first
  // ---------------------------------------------------------------
  always_comb begin
    next_state.first  = pin;
    next_state.second = state.first;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= '{first: reset_value, second: reset_value};
    end else begin
      state <= next_state;
    end
  end

  assign level = state.second;

endmodule

`default_nettype wire

// ===== rtl/net_ctrl_slice.sv
`timescale 1ns/1ps
`default_nettype none
`include "pot_status_terminal_defs.svh"

module net_ctrl_slice (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // control
  input  wire logic       load_default,
  input  wire logic       write,
  input  wire logic [3:0] wdata,
  input  wire logic       lock,
  input  wire logic       apply,
  // values
  output logic      [3:0] staged,
  output logic      [3:0] applied
);

  pot_status_terminal_pkg::net_ctrl_state_t state;
  pot_status_terminal_pkg::net_ctrl_state_t next_state;

  // ---------------------------------------------------------------
  // staged value, copied to switches at command end
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (apply && state.pending) begin
      next_state.applied = state.staged;
      next_state.pending = 1'b0;
    end
    if (write && !lock) begin
      next_state.staged  = wdata;
      next_state.pending = 1'b1;
    end
    if (load_default) begin
      next_state.staged  = `NET_CTRL_RESET;
      next_state.applied = `NET_CTRL_RESET;
      next_state.pending = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= '{staged: `NET_CTRL_RESET, applied: `NET_CTRL_RESET, pending: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign staged  = state.staged;
  assign applied = state.applied;

endmodule

`default_nettype wire

// ===== rtl/pot_status_terminal_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "pot_status_terminal_defs.svh"

module pot_status_terminal_ctrl (
  // clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RST_B,
  // power and reset events
  input  wire logic       POWER_UP_OR_BROWNOUT,
  input  wire logic       RESET_PIN_B,
  // device pins
  input  wire logic       WP_PIN_B,
  input  wire logic       SHDN_PIN_B,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  // nonvolatile engine
  input  wire logic [3:0] NV_LOCK,
  input  wire logic       NV_PROTECT,
  input  wire logic       NV_PROG_DONE,
  input  wire logic       NV_WRITE_ACTIVE,
  // decoded serial commands
  input  wire logic       CMD_VALID,
  input  wire logic       CMD_WRITE,
  input  wire logic [3:0] CMD_ADDR,
  input  wire logic [8:0] CMD_WDATA,
  // command answers
  output logic      [8:0] RD_DATA,
  output logic            RD_VALID,
  output logic            CMD_ERROR,
  // wiper and memory write strobes
  output logic      [3:0] VOL_WIPER_WE,
  output logic      [3:0] NV_WIPER_WE,
  output logic            GP_NV_WE,
  output logic      [8:0] WR_DATA,
  // terminal switches
  output logic      [3:0] NET_SHUTDOWN,
  output logic      [3:0] TERM_A_CONNECT,
  output logic      [3:0] TERM_W_CONNECT,
  output logic      [3:0] TERM_B_CONNECT
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  pot_status_terminal_pkg::top_state_t state;
  pot_status_terminal_pkg::top_state_t next_state;

  logic [3:0] pin_level;
  logic       wp_pin_b_s;
  logic       shdn_pin_b_s;
  logic       scl_s;
  logic       sda_s;
  logic       rst_pin_b_s;

  logic [3:0] net_staged [4];
  logic [3:0] net_applied [4];
  logic [3:0] net_write;
  logic [3:0] net_wdata [4];

  logic       protect;
  logic       stop_seen;
  logic       cmd_live;
  logic       is_nv_addr;
  logic       is_vol_addr;
  logic [8:0] status_word;
  logic [8:0] term_low_word;
  logic [8:0] term_high_word;
  logic       reload;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  pin_sync2 #(
    .WIDTH (4)
  ) u_pin_sync (
    .clk         (SYS_CLK),
    .rst_b       (RST_B),
    .pin         ({WP_PIN_B, SHDN_PIN_B, SCL_IN, SDA_IN}),
    .reset_value (4'hf),
    .level       (pin_level)
  );

  pin_sync2 #(
    .WIDTH (1)
  ) u_rst_pin_sync (
    .clk         (SYS_CLK),
    .rst_b       (RST_B),
    .pin         (RESET_PIN_B),
    .reset_value (1'b1),
    .level       (rst_pin_b_s)
  );

  assign wp_pin_b_s   = pin_level[3];
  assign shdn_pin_b_s = pin_level[2];
  assign scl_s        = pin_level[1];
  assign sda_s        = pin_level[0];

  // ---------------------------------------------------------------
  // end of serial command: data rises while clock high
  // ---------------------------------------------------------------
  assign stop_seen = scl_s && state.scl_q && sda_s && !state.sda_q;

  // ---------------------------------------------------------------
  // address classes and gating
  // ---------------------------------------------------------------
  assign protect  = !wp_pin_b_s || state.nv_protect;
  assign cmd_live = CMD_VALID && (state.phase == pot_status_terminal_pkg::ST_RUN);
  assign reload   = !rst_pin_b_s || POWER_UP_OR_BROWNOUT;

  always_comb begin
    is_nv_addr = 1'b0;
    case (CMD_ADDR)
      `ADDR_NV_WIPER0,
      `ADDR_NV_WIPER1,
      `ADDR_NV_WIPER2,
      `ADDR_NV_WIPER3: is_nv_addr = 1'b1;
      default:         is_nv_addr = (CMD_ADDR >= `ADDR_GP_FIRST);
    endcase
  end

  always_comb begin
    is_vol_addr = 1'b0;
    case (CMD_ADDR)
      `ADDR_VOL_WIPER0,
      `ADDR_VOL_WIPER1,
      `ADDR_TERM_LOW,
      `ADDR_LOCK_STATE: is_vol_addr = 1'b1;
      default:          is_vol_addr = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // read words
  // ---------------------------------------------------------------
  always_comb begin
    status_word                 = 9'h000;
    status_word[`ST_RSV_TOP_HI] = 1'b1;
    status_word[`ST_RSV_TOP_LO] = 1'b1;
    status_word[`ST_LOCK_NET3]  = state.lock[3];
    status_word[`ST_LOCK_NET2]  = state.lock[2];
    status_word[`ST_NV_BUSY]    = NV_WRITE_ACTIVE;
    status_word[`ST_LOCK_NET1]  = state.lock[1];
    status_word[`ST_LOCK_NET0]  = state.lock[0];
    status_word[`ST_RSV_ONE]    = 1'b1;
    status_word[`ST_PROTECT]    = protect;
  end

  // ---------------------------------------------------------------
  // control words, reserved top bit forced to one
  // ---------------------------------------------------------------
  always_comb begin
    term_low_word                            = 9'h000;
    term_low_word[`TC_RESERVED_TOP]          = 1'b1;
    term_low_word[`TC_UPPER_HI:`TC_UPPER_LO] = net_staged[1];
    term_low_word[`TC_LOWER_HI:`TC_LOWER_LO] = net_staged[0];
  end

  always_comb begin
    term_high_word                            = 9'h000;
    term_high_word[`TC_RESERVED_TOP]          = 1'b1;
    term_high_word[`TC_UPPER_HI:`TC_UPPER_LO] = net_staged[3];
    term_high_word[`TC_LOWER_HI:`TC_LOWER_LO] = net_staged[2];
  end

  // ---------------------------------------------------------------
  // terminal control write split per network
  // ---------------------------------------------------------------
  always_comb begin
    net_write    = 4'h0;
    net_wdata[0] = CMD_WDATA[`TC_LOWER_HI:`TC_LOWER_LO];
    net_wdata[1] = CMD_WDATA[`TC_UPPER_HI:`TC_UPPER_LO];
    net_wdata[2] = CMD_WDATA[`TC_LOWER_HI:`TC_LOWER_LO];
    net_wdata[3] = CMD_WDATA[`TC_UPPER_HI:`TC_UPPER_LO];
    if (cmd_live && CMD_WRITE && !reload) begin
      if (CMD_ADDR == `ADDR_TERM_LOW) begin
        net_write[1:0] = 2'b11;
      end
      if (CMD_ADDR == `ADDR_TERM_HIGH && !NV_WRITE_ACTIVE) begin
        net_write[3:2] = 2'b11;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_net
      net_ctrl_slice u_net (
        .clk          (SYS_CLK),
        .rst_b        (RST_B),
        .load_default (POWER_UP_OR_BROWNOUT),
        .write        (net_write[g]),
        .wdata        (net_wdata[g]),
        .lock         (state.lock[g]),
        .apply        (state.apply),
        .staged       (net_staged[g]),
        .applied      (net_applied[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state           = state;
    next_state.rd_valid  = 1'b0;
    next_state.cmd_error = 1'b0;
    next_state.vol_we    = 4'h0;
    next_state.nv_we     = 4'h0;
    next_state.gp_we     = 1'b0;
    next_state.scl_q     = scl_s;
    next_state.sda_q     = sda_s;
    next_state.apply     = stop_seen;

    // lock and protect copies
    case (state.phase)
      pot_status_terminal_pkg::ST_LOAD: begin
        next_state.lock       = NV_LOCK;
        next_state.nv_protect = NV_PROTECT;
        next_state.phase      = pot_status_terminal_pkg::ST_RUN;
      end
      pot_status_terminal_pkg::ST_RUN: begin
        if (NV_PROG_DONE) begin
          next_state.lock       = NV_LOCK;
          next_state.nv_protect = NV_PROTECT;
        end
      end
      default: begin
        next_state.phase = pot_status_terminal_pkg::ST_LOAD;
      end
    endcase
    if (reload) begin
      next_state.phase = pot_status_terminal_pkg::ST_LOAD;
    end

    // ---------------------------------------------------------------
    // command decode
    // ---------------------------------------------------------------
    if (cmd_live && !reload) begin
      if (NV_WRITE_ACTIVE && !is_vol_addr) begin
        next_state.cmd_error = 1'b1;
      end else if (!CMD_WRITE) begin
        next_state.rd_valid = 1'b1;
        case (CMD_ADDR)
          `ADDR_LOCK_STATE: next_state.rd_data = status_word;
          `ADDR_TERM_LOW:   next_state.rd_data = term_low_word;
          `ADDR_TERM_HIGH:  next_state.rd_data = term_high_word;
          default:          next_state.rd_data = 9'h000;
        endcase
      end else begin
        next_state.wr_data = CMD_WDATA;
        case (CMD_ADDR)
          `ADDR_VOL_WIPER0: next_state.vol_we[0] = !state.lock[0];
          `ADDR_VOL_WIPER1: next_state.vol_we[1] = !state.lock[1];
          `ADDR_VOL_WIPER2: next_state.vol_we[2] = !state.lock[2];
          `ADDR_VOL_WIPER3: next_state.vol_we[3] = !state.lock[3];
          `ADDR_LOCK_STATE: next_state.cmd_error = 1'b1;
          `ADDR_TERM_LOW,
          `ADDR_TERM_HIGH:  next_state.cmd_error = 1'b0;
          default: begin
            if (protect && is_nv_addr) begin
              next_state.cmd_error = 1'b1;
            end else begin
              case (CMD_ADDR)
                `ADDR_NV_WIPER0: next_state.nv_we[0] = !state.lock[0];
                `ADDR_NV_WIPER1: next_state.nv_we[1] = !state.lock[1];
                `ADDR_NV_WIPER2: next_state.nv_we[2] = !state.lock[2];
                `ADDR_NV_WIPER3: next_state.nv_we[3] = !state.lock[3];
                default:         next_state.gp_we    = 1'b1;
              endcase
            end
          end
        endcase
      end
    end

    // ---------------------------------------------------------------
    // switch drive: cleared shutdown bit or active pin forces shutdown
    // ---------------------------------------------------------------
    for (int n = 0; n < 4; n = n + 1) begin
      next_state.shutdown[n] = !net_applied[n][`NET_SHDN_BIT] || !shdn_pin_b_s;
      next_state.term_a[n]   = net_applied[n][`NET_A_BIT];
      next_state.term_w[n]   = net_applied[n][`NET_W_BIT];
      next_state.term_b[n]   = net_applied[n][`NET_B_BIT];
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      state            <= '0;
      state.phase      <= pot_status_terminal_pkg::ST_LOAD;
      state.scl_q      <= 1'b1;
      state.sda_q      <= 1'b1;
      state.term_a     <= 4'hf;
      state.term_w     <= 4'hf;
      state.term_b     <= 4'hf;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign RD_DATA        = state.rd_data;
  assign RD_VALID       = state.rd_valid;
  assign CMD_ERROR      = state.cmd_error;
  assign VOL_WIPER_WE   = state.vol_we;
  assign NV_WIPER_WE    = state.nv_we;
  assign GP_NV_WE       = state.gp_we;
  assign WR_DATA        = state.wr_data;
  assign NET_SHUTDOWN   = state.shutdown;
  assign TERM_A_CONNECT = state.term_a;
  assign TERM_W_CONNECT = state.term_w;
  assign TERM_B_CONNECT = state.term_b;

endmodule

`default_nettype wire

// ===== testbench/pot_status_terminal_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module pot_status_terminal_ctrl_asserts (
  // clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RST_B,
  // events and pins
  input  wire logic       POWER_UP_OR_BROWNOUT,
  input  wire logic       RESET_PIN_B,
  input  wire logic       WP_PIN_B,
  input  wire logic       SDA_IN,
  input  wire logic       NV_WRITE_ACTIVE,
  // commands
  input  wire logic       CMD_VALID,
  input  wire logic       CMD_WRITE,
  input  wire logic [3:0] CMD_ADDR,
  // answers
  input  wire logic [8:0] RD_DATA,
  input  wire logic       RD_VALID,
  input  wire logic       CMD_ERROR,
  input  wire logic [3:0] VOL_WIPER_WE,
  input  wire logic [3:0] NV_WIPER_WE,
  input  wire logic       GP_NV_WE,
  input  wire logic [3:0] TERM_A_CONNECT,
  input  wire logic [3:0] TERM_W_CONNECT,
  input  wire logic [3:0] TERM_B_CONNECT
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  logic st_rd;
  logic quiet;
  assign st_rd = CMD_VALID && !CMD_WRITE && CMD_ADDR == 4'h5;
  assign quiet = RESET_PIN_B && !POWER_UP_OR_BROWNOUT;

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  a_reserved_ones: assert property (
    RD_VALID && $past(st_rd) |-> RD_DATA[8:7] == 2'b11 && RD_DATA[1])
    else $error("status reserved bits not one");
  a_busy_flag: assert property (
    RD_VALID && $past(st_rd) |-> RD_DATA[4] == $past(NV_WRITE_ACTIVE))
    else $error("busy bit wrong");
  a_busy_refuse: assert property (
    CMD_VALID && NV_WRITE_ACTIVE && !(CMD_ADDR inside {4'h0, 4'h1, 4'h4, 4'h5})
    |=> !RD_VALID && !GP_NV_WE && NV_WIPER_WE == 4'h0 && VOL_WIPER_WE == 4'h0)
    else $error("command served while busy");
  a_protect_nv: assert property (
    (!WP_PIN_B)[*4] ##0 (CMD_VALID && CMD_WRITE) |=> NV_WIPER_WE == 4'h0 && !GP_NV_WE)
    else $error("protected write reached memory");
  a_status_ro: assert property (
    CMD_VALID && CMD_WRITE && CMD_ADDR == 4'h5
    |=> VOL_WIPER_WE == 4'h0 && NV_WIPER_WE == 4'h0 && !GP_NV_WE && !RD_VALID)
    else $error("status write had effect");
  a_read_answer: assert property (
    quiet[*6] ##0 st_rd |=> RD_VALID && !CMD_ERROR)
    else $error("status read not answered");
  a_term_hold: assert property (
    ($stable(SDA_IN) && !POWER_UP_OR_BROWNOUT)[*8]
    |-> $stable({TERM_A_CONNECT, TERM_W_CONNECT, TERM_B_CONNECT}))
    else $error("terminals moved without stop");
  a_reset_terms: assert property (
    $rose(RST_B) |-> {TERM_A_CONNECT, TERM_W_CONNECT, TERM_B_CONNECT} == 12'hfff)
    else $error("terminals not connected after reset");
endmodule

bind pot_status_terminal_ctrl pot_status_terminal_ctrl_asserts chk_u (
  .SYS_CLK, .RST_B, .POWER_UP_OR_BROWNOUT, .RESET_PIN_B, .WP_PIN_B, .SDA_IN,
  .NV_WRITE_ACTIVE, .CMD_VALID, .CMD_WRITE, .CMD_ADDR, .RD_DATA, .RD_VALID,
  .CMD_ERROR, .VOL_WIPER_WE, .NV_WIPER_WE, .GP_NV_WE, .TERM_A_CONNECT,
  .TERM_W_CONNECT, .TERM_B_CONNECT);

`default_nettype wire

// ===== testbench/pot_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module pot_host_model (
  // frame request and completion
  input  wire logic start,
  output logic      done,
  // bus lines, pulled high while idle
  output logic      scl,
  output logic      sda
);
  // idle high, then per request: start, four clocks with data low, stop
  initial begin
    scl  = 1'b1;
    sda  = 1'b1;
    done = 1'b0;
    forever begin
      @(posedge start);
      done = 1'b0;
      #80 sda = 1'b0;
      repeat (4) begin
        #80 scl = 1'b0;
        #80 scl = 1'b1;
      end
      #40 sda = 1'b1;
      #80 done = 1'b1;
    end
  end
endmodule

`default_nettype wire

// ===== testbench/pot_status_terminal_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module pot_status_terminal_ctrl_tb_top;
  // ---------------------------------------------------------------
  // stimulus and answers
  // ---------------------------------------------------------------
  logic       clk = 0, rst_b = 0, pwr = 0, rpin_b = 1, wp_b = 1, shdn_b = 1;
  logic       nv_prot = 0, pdone = 0, busy = 0, cv = 0, cw = 0, go = 0;
  logic [3:0] nv_lock = 4'h0, ca = 4'h0;
  logic [8:0] cd = 9'h000;
  logic       scl, sda, rd_v, err, gp_we, fdone;
  logic [3:0] vol_we, nv_we, shut, ta, tw, tb;
  logic [8:0] rd, wr;
  logic       g_err;
  logic [3:0] g_vol;
  logic [8:0] g_rd;
  logic [3:0] vaddr [4] = '{4'h0, 4'h1, 4'h6, 4'h7};
  int         num_errors = 0;
  int         checks_done = 0;

  always #10 clk = ~clk;

  pot_host_model host_u (.start(go), .done(fdone), .scl(scl), .sda(sda));

  pot_status_terminal_ctrl dut_u (
    .SYS_CLK(clk), .RST_B(rst_b), .POWER_UP_OR_BROWNOUT(pwr), .RESET_PIN_B(rpin_b),
    .WP_PIN_B(wp_b), .SHDN_PIN_B(shdn_b), .SCL_IN(scl), .SDA_IN(sda),
    .NV_LOCK(nv_lock), .NV_PROTECT(nv_prot), .NV_PROG_DONE(pdone),
    .NV_WRITE_ACTIVE(busy), .CMD_VALID(cv), .CMD_WRITE(cw), .CMD_ADDR(ca),
    .CMD_WDATA(cd), .RD_DATA(rd), .RD_VALID(rd_v), .CMD_ERROR(err),
    .VOL_WIPER_WE(vol_we), .NV_WIPER_WE(nv_we), .GP_NV_WE(gp_we), .WR_DATA(wr),
    .NET_SHUTDOWN(shut), .TERM_A_CONNECT(ta), .TERM_W_CONNECT(tw),
    .TERM_B_CONNECT(tb));

  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one command, answer sampled in the cycle after it is taken
  task automatic cmd(input logic w, input logic [3:0] a, input logic [8:0] d);
    @(negedge clk);
    cv = 1'b1;
    cw = w;
    ca = a;
    cd = d;
    @(negedge clk);
    g_err = err;
    g_vol = vol_we | nv_we;
    g_rd = (rd_v === 1'b1) ? rd : 9'hxxx;
    if (gp_we === 1'b1) g_vol = 4'hf;
    cv = 1'b0;
  endtask

  task automatic prog(input logic [3:0] l, input logic p);
    nv_lock = l;
    nv_prot = p;
    pdone = 1'b1;
    ticks(1);
    pdone = 1'b0;
    ticks(1);
  endtask

  task automatic t_reset;
    check({1'b0, shut, ta}, 9'h00f);
    check({1'b0, tw, tb}, 9'h0ff);
    cmd(0, 4'h4, 9'h000);
    check(g_rd, 9'h1ff);
    cmd(0, 4'ha, 9'h000);
    check(g_rd, 9'h1ff);
    $display("test reset done");
  endtask

  task automatic t_protect;
    cmd(0, 4'h5, 9'h000);
    check(g_rd, 9'h182);
    wp_b = 1'b0;
    ticks(4);
    cmd(0, 4'h5, 9'h000);
    check(g_rd, 9'h183);
    cmd(1, 4'h2, 9'h040);
    check({4'h0, g_err, g_vol}, 9'h010);
    cmd(1, 4'hb, 9'h040);
    check({4'h0, g_err, g_vol}, 9'h010);
    cmd(1, 4'h0, 9'h040);
    check({4'h0, g_err, g_vol}, 9'h001);
    check(wr, 9'h040);
    cmd(1, 4'h4, 9'h1ff);
    check({8'h00, g_err}, 9'h000);
    wp_b = 1'b1;
    ticks(4);
    cmd(1, 4'h8, 9'h040);
    check({4'h0, g_err, g_vol}, 9'h004);
    $display("test protect done");
  endtask

  task automatic t_busy;
    busy = 1'b1;
    cmd(0, 4'h5, 9'h000);
    check(g_rd, 9'h192);
    cmd(0, 4'h2, 9'h000);
    check({8'h00, g_err}, 9'h001);
    cmd(1, 4'h1, 9'h010);
    check({4'h0, g_err, g_vol}, 9'h002);
    cmd(1, 4'ha, 9'h1ff);
    check({8'h00, g_err}, 9'h001);
    busy = 1'b0;
    $display("test busy done");
  endtask

  task automatic t_apply;
    cmd(1, 4'h4, 9'h0a5);
    cmd(1, 4'ha, 9'h05a);
    cmd(0, 4'h4, 9'h000);
    check(g_rd, 9'h1a5);
    cmd(0, 4'ha, 9'h000);
    check(g_rd, 9'h15a);
    ticks(10);
    check({1'b0, shut, ta}, 9'h00f);
    go = 1'b1;
    @(posedge fdone);
    go = 1'b0;
    ticks(8);
    check({1'b0, shut, ta}, 9'h099);
    check({1'b0, tw, tb}, 9'h069);
    shdn_b = 1'b0;
    ticks(4);
    check({1'b0, shut, ta}, 9'h0f9);
    shdn_b = 1'b1;
    ticks(4);
    check({1'b0, shut, ta}, 9'h099);
    $display("test apply done");
  endtask

  task automatic t_lock;
    prog(4'hf, 1'b1);
    cmd(0, 4'h5, 9'h000);
    check(g_rd, 9'h1ef);
    foreach (vaddr[i]) begin
      cmd(1, vaddr[i], 9'h011);
      check({4'h0, g_err, g_vol}, 9'h000);
    end
    cmd(1, 4'h5, 9'h000);
    check({8'h00, g_err}, 9'h001);
    cmd(0, 4'h5, 9'h000);
    check(g_rd, 9'h1ef);
    prog(4'ha, 1'b0);
    cmd(1, 4'h4, 9'h000);
    cmd(1, 4'ha, 9'h000);
    cmd(0, 4'h4, 9'h000);
    check(g_rd, 9'h1a0);
    cmd(0, 4'ha, 9'h000);
    check(g_rd, 9'h150);
    prog(4'h0, 1'b0);
    $display("test lock done");
  endtask

  task automatic t_power;
    pwr = 1'b1;
    ticks(2);
    pwr = 1'b0;
    ticks(10);
    check({shut, ta, 1'b1}, 9'h01f);
    cmd(0, 4'h4, 9'h000);
    check(g_rd, 9'h1ff);
    cmd(1, 4'h4, 9'h1ff);
    nv_lock = 4'h1;
    rpin_b = 1'b0;
    ticks(4);
    rpin_b = 1'b1;
    ticks(8);
    cmd(0, 4'h5, 9'h000);
    check(g_rd, 9'h186);
    $display("test power done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200us;
    num_errors++;
    test_done;
  end

  initial begin
    ticks(10);
    rst_b = 1'b1;
    ticks(3);
    t_reset;
    t_protect;
    t_busy;
    t_apply;
    t_lock;
    t_power;
    test_done;
  end
endmodule

`default_nettype wire
